//--- verilog/uhie_consts.svh
`ifndef UHIE_CONSTS_SVH
`define UHIE_CONSTS_SVH
// Overview of operation
// - each mask bit gates its own status bit
// - irq when a status bit 0-6, its mask bit and master gate set
// - writing one sets the mask bit
// - writing zero leaves mask bit unchanged
// - mask read returns value, no side effect
// - mask register decoded at offset 0x10
// - status sticky, set by event, W1C
// - unmasked ownership change drives management irq

// ----------------------------------------------------------------
// register offsets, fields and reset values
// ----------------------------------------------------------------
`define UHIE_OFS_STATUS   8'h0c
`define UHIE_OFS_MASK     8'h10
`define UHIE_BIT_OC       30
`define UHIE_BIT_MIE      31
`define UHIE_STAT_IMPL    32'h4000_007f
`define UHIE_MASK_IMPL    32'hc000_007f
`define UHIE_IRQ_SRC      32'h0000_007f
`define UHIE_RST_MASK     32'h0000_0000
`define UHIE_RST_STATUS   32'h0000_0000

`endif

//--- verilog/uhie_pkg.sv
package uhie_pkg;
  // state of the status holder
  typedef struct packed {
    logic [31:0] status;
  } uhie_stat_st_t;

  // state of the top block
  typedef struct packed {
    logic [31:0] mask;
    logic        irq;
    logic        smi_n;
    logic [31:0] rdata;
    logic        rvalid;
  } uhie_top_st_t;
endpackage

//--- verilog/uhie_stat_if.sv
`timescale 1ns/1ps
interface uhie_stat_if;
  logic [31:0] set;
  logic [31:0] clr;
  logic [31:0] status;
  modport owner (input set, input clr, output status);
  modport user  (output set, output clr, input status);
endinterface

//--- verilog/uhie_status.sv
`timescale 1ns/1ps
`include "uhie_consts.svh"
module uhie_status
  import uhie_pkg::*;
(
  input  wire logic   i_clk,
  input  wire logic   i_rst_n,
  uhie_stat_if.owner  stat
);
  uhie_stat_st_t st_r;
  uhie_stat_st_t st_nxt;
  logic [31:0]   bit_nxt;
  logic [31:0]   impl;

  assign impl = `UHIE_STAT_IMPL;

  // ----------------------------------------------------------------
  // per-bit sticky flags, set beats clear
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_bit
      assign bit_nxt[gi] = impl[gi] &
        (stat.set[gi] | (st_r.status[gi] & ~stat.clr[gi]));
    end
  endgenerate

  // next state
  always_comb begin
    st_nxt        = st_r;
    st_nxt.status = bit_nxt;
  end

  // state register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r.status <= `UHIE_RST_STATUS;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign stat.status = st_r.status;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_STAT_SET: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (stat.set[`UHIE_BIT_OC] || stat.set[0]) |=>
      (stat.status[`UHIE_BIT_OC] || !$past(stat.set[`UHIE_BIT_OC])) &&
      (stat.status[0] || !$past(stat.set[0])))
    else $error("event did not set its status bit");
  AST_STAT_STICKY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    1'b1 |=> ((($past(stat.status) & ~$past(stat.clr)) & ~stat.status) == 32'h0)
  ) else $error("status bit fell without a clear");
  AST_STAT_SET_WINS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    |(stat.set & stat.clr & impl) |=>
      ((stat.status & $past(stat.set & stat.clr & impl)) == $past(stat.set & stat.clr & impl))
  ) else $error("clear beat a coinciding event");
endmodule // uhie_status

//--- verilog/uhie_top.sv
`timescale 1ns/1ps
`include "uhie_consts.svh"
module uhie_top
  import uhie_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [31:0] i_event,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  output logic [31:0]      o_reg_rdata,
  output logic             o_reg_rvalid,
  output logic             o_irq,
  output logic             o_system_management_irq_pin_n
);
  uhie_top_st_t st_r;
  uhie_top_st_t st_nxt;
  uhie_stat_if  stat ();
  logic         wr_mask;
  logic         wr_stat;
  logic         rd_mask;
  logic         rd_stat;
  logic [31:0]  gated;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  assign wr_mask = i_reg_wr && (i_reg_addr == `UHIE_OFS_MASK);
  assign wr_stat = i_reg_wr && (i_reg_addr == `UHIE_OFS_STATUS);
  assign rd_mask = i_reg_rd && (i_reg_addr == `UHIE_OFS_MASK);
  assign rd_stat = i_reg_rd && (i_reg_addr == `UHIE_OFS_STATUS);

  // status holder hookup
  assign stat.set = i_event;
  assign stat.clr = wr_stat ? i_reg_wdata : 32'h0;

  uhie_status u_status (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .stat    (stat.owner)
  );

  // bitwise pairing of status and mask
  assign gated = stat.status & st_r.mask;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt        = st_r;
    st_nxt.rvalid = i_reg_rd;
    st_nxt.rdata  = 32'h0;
    if (wr_mask) begin
      st_nxt.mask = st_r.mask | (i_reg_wdata & `UHIE_MASK_IMPL);
    end
    if (rd_mask) begin
      st_nxt.rdata = st_r.mask;
    end else if (rd_stat) begin
      st_nxt.rdata = stat.status;
    end
    st_nxt.irq   = st_r.mask[`UHIE_BIT_MIE] && |(gated & `UHIE_IRQ_SRC);
    st_nxt.smi_n = ~gated[`UHIE_BIT_OC];
  end

  // state register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r.mask   <= `UHIE_RST_MASK;
      st_r.irq    <= 1'b0;
      st_r.smi_n  <= 1'b1;
      st_r.rdata  <= 32'h0;
      st_r.rvalid <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_reg_rdata                   = st_r.rdata;
  assign o_reg_rvalid                  = st_r.rvalid;
  assign o_irq                         = st_r.irq;
  assign o_system_management_irq_pin_n = st_r.smi_n;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_mask_wr;
    i_reg_wr && (i_reg_addr == `UHIE_OFS_MASK);
  endsequence
  sequence s_mask_rd_only;
    i_reg_rd && !i_reg_wr && (i_reg_addr == `UHIE_OFS_MASK);
  endsequence

  AST_MASK_SET: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_mask_wr |=> ((st_r.mask & $past(i_reg_wdata) & `UHIE_MASK_IMPL) ==
                   ($past(i_reg_wdata) & `UHIE_MASK_IMPL))
  ) else $error("mask write did not set bits");
  AST_MASK_NOCLR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    1'b1 |=> (($past(st_r.mask) & ~st_r.mask) == 32'h0)
  ) else $error("mask bit was cleared");
  AST_MASK_ONLY_WR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    1'b1 |=> ((st_r.mask & ~$past(st_r.mask) & ~$past(wr_mask ? i_reg_wdata : 32'h0))
              == 32'h0)
  ) else $error("mask bit set without a write of one");
  AST_MASK_RD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_mask_rd_only |=> o_reg_rvalid && (o_reg_rdata == $past(st_r.mask)) &&
                       $stable(st_r.mask)
  ) else $error("mask read wrong or had a side effect");
  AST_WRONG_OFS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_reg_wr && (i_reg_addr != `UHIE_OFS_MASK)) |=> $stable(st_r.mask)
  ) else $error("mask changed by write to other offset");
  AST_IRQ_ON: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_r.mask[`UHIE_BIT_MIE] && |(gated & `UHIE_IRQ_SRC)) |=> o_irq
  ) else $error("irq missing while gate holds");
  AST_IRQ_OFF: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !(st_r.mask[`UHIE_BIT_MIE] && |(gated & `UHIE_IRQ_SRC)) |=> !o_irq
  ) else $error("irq asserted without gate");
  AST_SMI: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    gated[`UHIE_BIT_OC] |=> !o_system_management_irq_pin_n
  ) else $error("management irq not driven for unmasked ownership change");
  AST_CLR_IRQ: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (wr_stat && (i_reg_wdata == 32'hffff_ffff) && (i_event == 32'h0)) |=> ##1 !o_irq
  ) else $error("irq stayed after all status cleared");

  // ----------------------------------------------------------------
  // read path checks
  // ----------------------------------------------------------------
  sequence s_any_rd;
    i_reg_rd;
  endsequence
  sequence s_stat_rd;
    i_reg_rd && (i_reg_addr == `UHIE_OFS_STATUS);
  endsequence
  sequence s_unmapped_rd;
    i_reg_rd && (i_reg_addr != `UHIE_OFS_MASK) &&
    (i_reg_addr != `UHIE_OFS_STATUS);
  endsequence
  sequence s_quiet_rd;
    i_reg_rd && !i_reg_wr && (i_event == 32'h0);
  endsequence

  // answer comes one cycle after the strobe and stands one cycle
  AST_RVALID_ON: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_any_rd |=> o_reg_rvalid
  ) else $error("read strobe got no answer");
  AST_RVALID_OFF: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !i_reg_rd |=> !o_reg_rvalid
  ) else $error("answer without a read strobe");
  AST_RDATA_IDLE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !i_reg_rd |=> (o_reg_rdata == 32'h0)
  ) else $error("read data not zero outside an answer");

  // data returned per offset
  AST_RD_STAT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_stat_rd |=> (o_reg_rdata == $past(stat.status))
  ) else $error("status read returned a wrong value");
  AST_RD_UNMAPPED: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_unmapped_rd |=> (o_reg_rdata == 32'h0)
  ) else $error("unmapped offset returned data");
  AST_RD_RSVD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_reg_rvalid |->
      ((o_reg_rdata & ~(`UHIE_MASK_IMPL | `UHIE_STAT_IMPL)) == 32'h0)
  ) else $error("reserved bits read as one");

  // a plain read leaves mask and status alone
  AST_RD_NO_SIDE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_quiet_rd |=> $stable(st_r.mask) && $stable(stat.status)
  ) else $error("read changed the interrupt state");

  // ----------------------------------------------------------------
  // write path checks
  // ----------------------------------------------------------------
  sequence s_stat_wr_quiet;
    wr_stat && (i_event == 32'h0);
  endsequence
  sequence s_unmapped_wr;
    i_reg_wr && (i_reg_addr != `UHIE_OFS_MASK) &&
    (i_reg_addr != `UHIE_OFS_STATUS) && (i_event == 32'h0);
  endsequence

  // mask after a write is the old mask plus the ones written
  AST_MASK_WR_EXACT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_mask_wr |=> (st_r.mask ==
                   ($past(st_r.mask) | ($past(i_reg_wdata) & `UHIE_MASK_IMPL)))
  ) else $error("mask write gave a wrong value");

  // status cleared by writing one, never set by a write
  AST_STAT_W1C: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_stat_wr_quiet |=> ((stat.status & $past(i_reg_wdata)) == 32'h0)
  ) else $error("status bit survived a write of one");
  AST_STAT_NO_SET: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_stat_wr_quiet |=> ((stat.status & ~$past(stat.status)) == 32'h0)
  ) else $error("status bit set by a register write");

  // writes outside their own offset touch nothing
  AST_WR_UNMAPPED: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_unmapped_wr |=> $stable(st_r.mask) && $stable(stat.status)
  ) else $error("unmapped write changed the interrupt state");
  AST_MASK_WR_STAT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (wr_mask && (i_event == 32'h0)) |=> $stable(stat.status)
  ) else $error("mask write changed the status");

  // ----------------------------------------------------------------
  // interrupt output checks
  // ----------------------------------------------------------------
  sequence s_evt_enabled;
    st_r.mask[`UHIE_BIT_MIE] && |(i_event & st_r.mask & `UHIE_IRQ_SRC);
  endsequence
  sequence s_no_src;
    (stat.status & `UHIE_IRQ_SRC) == 32'h0;
  endsequence

  // no request without the master gate or without a source
  AST_IRQ_NO_MIE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !st_r.mask[`UHIE_BIT_MIE] |=> !o_irq
  ) else $error("irq raised with master gate off");
  AST_IRQ_NO_SRC: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_no_src |=> !o_irq
  ) else $error("irq raised with no pending source");

  // enabled event reaches the pin two cycles later
  AST_EVT_TO_IRQ: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_evt_enabled |-> ##2 o_irq
  ) else $error("enabled event did not raise irq");

  // request stands while the gate holds
  AST_IRQ_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_irq && st_r.mask[`UHIE_BIT_MIE] && |(gated & `UHIE_IRQ_SRC)) |=> o_irq
  ) else $error("irq dropped while the gate held");

  // management pin released once ownership change is gone or masked
  AST_SMI_OFF: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !gated[`UHIE_BIT_OC] |=> o_system_management_irq_pin_n
  ) else $error("management irq driven without its source");
endmodule // uhie_top

//--- verification/uhie_evt_src.sv
`timescale 1ns/1ps
// event source standing in for the controller's event logic
module uhie_evt_src (
  input  wire logic        i_clk,
  output logic [31:0]      o_event
);
  initial o_event = 32'h0000_0000;
  // ----------------------------------------------------------------
  // one-cycle event pulse, sets the sticky status bit
  // ----------------------------------------------------------------
  task automatic fire(input int b);
    @(posedge i_clk) o_event <= 32'h0000_0001 << b;
    @(posedge i_clk) o_event <= 32'h0000_0000;
  endtask
endmodule // uhie_evt_src

//--- verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic i_clk = 0, i_rst_n = 0, i_reg_wr = 0, i_reg_rd = 0;
  logic [7:0] i_reg_addr = 8'h00;
  logic [31:0] i_reg_wdata = 32'h0000_0000, i_event, o_reg_rdata;
  logic o_reg_rvalid, o_irq, smi_n;
  int bad_count = 0, tests_run = 0;
  // clock at 125 MHz
  always #4 i_clk = ~i_clk;
  uhie_evt_src i_src (.i_clk(i_clk), .o_event(i_event));
  uhie_top i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_event(i_event),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .o_reg_rvalid(o_reg_rvalid), .o_irq(o_irq), .o_system_management_irq_pin_n(smi_n));
  // ----------------------------------------------------------------
  // access tasks and compare
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk) begin
      i_reg_wr <= 1'b1; i_reg_addr <= a; i_reg_wdata <= d;
    end
    @(posedge i_clk) i_reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clk) begin
      i_reg_rd <= 1'b1; i_reg_addr <= a;
    end
    @(posedge i_clk) i_reg_rd <= 1'b0;
    #1 chk({31'h0000_0000, o_reg_rvalid}, 32'h0000_0001);
    chk(o_reg_rdata, exp);
  endtask
  // wait for status then level outputs to settle
  task automatic pins(input logic irq, input logic smin);
    repeat (3) @(posedge i_clk);
    #1 chk({30'h0, o_irq, smi_n}, {30'h0, irq, smin});
  endtask
  task automatic reset_dut();
    @(posedge i_clk) i_rst_n <= 1'b0;
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
  endtask
  task automatic results();
    $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // watchdog against a hung run
  initial begin
    #50000;
    bad_count++;
    results();
  end
  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(8'h10, 32'h0000_0000);
    wr(8'h10, 32'h8000_0005);
    rd(8'h10, 32'h8000_0005);
    wr(8'h10, 32'h0000_0002);
    wr(8'h10, 32'h0000_0000);
    rd(8'h10, 32'h8000_0007);
    wr(8'h14, 32'hffff_ffff);
    rd(8'h14, 32'h0000_0000);
    rd(8'h10, 32'h8000_0007);
    $display("test mask done");
    i_src.fire(2);
    pins(1'b1, 1'b1);
    rd(8'h10, 32'h8000_0007);
    wr(8'h0c, 32'h0000_0004);
    pins(1'b0, 1'b1);
    i_src.fire(3);
    pins(1'b0, 1'b1);
    rd(8'h0c, 32'h0000_0008);
    wr(8'h0c, 32'h0000_0008);
    fork
      i_src.fire(5);
      wr(8'h0c, 32'h0000_0020);
    join
    rd(8'h0c, 32'h0000_0020);
    wr(8'h0c, 32'h0000_0020);
    $display("test gate done");
    reset_dut();
    rd(8'h10, 32'h0000_0000);
    wr(8'h10, 32'h0000_0010);
    i_src.fire(4);
    pins(1'b0, 1'b1);
    wr(8'h10, 32'h8000_0000);
    pins(1'b1, 1'b1);
    i_src.fire(30);
    pins(1'b1, 1'b1);
    wr(8'h10, 32'h4000_0000);
    pins(1'b1, 1'b0);
    wr(8'h0c, 32'hffff_ffff);
    pins(1'b0, 1'b1);
    $display("test master done");
    results();
  end
endmodule // tb_top
